//--- shared/fdmu_pkg.sv
// Purpose: constants and carrier types for the fp doubleword move unit
// Assumes: one clock, synchronous active-high reset
// Notes: shared by the move unit and its fp register file
//
// Functional notes
// - decode major 010001, sub-op 00101 to-fp or 00001 from-fp, low 11 bits zero
// - move-to with 64-bit fp registers writes all 64 bits into one register
// - with 32-bit fp registers a doubleword lives in an even/odd pair
// - 32-bit move-to: low word to even register, high word to next one
// - native 32-bit and 32-bit emulation are handled the same way
// - in 32-bit mode only an even specifier is valid for doublewords
// - odd specifier in 32-bit mode: undefined result, no other state touched
// - move-from copies the doubleword; 32-bit mode joins odd high, even low
// - level four: results visible to the very next instruction
package fdmu_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned INSTR_W = 32;
  localparam int unsigned XLEN = 64;
  localparam int unsigned HALF_W = 32;
  localparam int unsigned SPEC_W = 5;
  localparam int unsigned NUM_FP_REGS = 32;
  localparam int unsigned FP_RD_PORTS = 3;
  localparam int unsigned FP_WR_PORTS = 2;

  // ----------------------------------------------------------------
  // instruction field positions
  // ----------------------------------------------------------------
  localparam int unsigned OPC_HI = 31;
  localparam int unsigned OPC_LO = 26;
  localparam int unsigned SUB_HI = 25;
  localparam int unsigned SUB_LO = 21;
  localparam int unsigned INT_SPEC_HI = 20;
  localparam int unsigned INT_SPEC_LO = 16;
  localparam int unsigned FP_SPEC_HI = 15;
  localparam int unsigned FP_SPEC_LO = 11;
  localparam int unsigned PAD_HI = 10;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] FP_COPROC_MAJOR_OPCODE = 6'h11;
  localparam logic [4:0] TO_FP_SUBOP = 5'h05;
  localparam logic [4:0] FROM_FP_SUBOP = 5'h01;
  localparam logic [10:0] PAD_ZERO = 11'h000;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [63:0] DATA_RST = 64'h0;
  localparam logic [4:0] IDX_RST = 5'h00;
  localparam logic [31:0] HALF_ZERO = 32'h0;
  localparam int unsigned RESULT_LATENCY = 1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] instr;
    logic [XLEN-1:0] int_rd_data;
  } fdmu_issue_t;

  typedef struct packed {
    logic fr64;
    logic dword_en;
    logic level_ge3;
  } fdmu_mode_t;

  typedef struct packed {
    logic valid;
    logic [SPEC_W-1:0] idx;
    logic [XLEN-1:0] data;
  } fdmu_int_wr_t;

  typedef struct packed {
    logic en;
    logic [SPEC_W-1:0] idx;
    logic [XLEN-1:0] data;
  } fdmu_fp_wr_t;

  typedef struct packed {
    fdmu_int_wr_t int_wr;
    logic ri_exc;
    logic to_done;
    logic [XLEN-1:0] obs_data;
  } fdmu_state_t;

endpackage

//--- hw/fdmu_fp_regfile.sv
// Purpose: fp register file, flip-flop storage addressed by specifier
// Assumes: write ports never name the same entry in one cycle for valid moves
// Notes: reads are combinational, so a write lands before the next read
module fdmu_fp_regfile
  import fdmu_pkg::*;
#(
  parameter int unsigned NUM_REGS = NUM_FP_REGS
) (
  input wire logic clk,
  input wire logic srst,
  input wire fdmu_fp_wr_t [FP_WR_PORTS-1:0] wr,
  input wire logic [FP_RD_PORTS-1:0][SPEC_W-1:0] rd_idx,
  output logic [FP_RD_PORTS-1:0][XLEN-1:0] rd_data
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_REGS != (1 << SPEC_W)) begin : g_bad_size
    $error("fp register count must match the specifier width");
  end

  typedef struct packed {
    logic [NUM_REGS-1:0][XLEN-1:0] regs;
  } fdmu_rf_state_t;

  fdmu_rf_state_t st_r;
  fdmu_rf_state_t st_nxt;
  logic [NUM_REGS-1:0][XLEN-1:0] ent_nxt;

  // ----------------------------------------------------------------
  // per-entry write select
  // ----------------------------------------------------------------
  // port 1 wins a clash; only an undefined odd-pair case could collide
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_ent
    always_comb begin
      ent_nxt[i] = st_r.regs[i];
      if (wr[0].en && wr[0].idx == SPEC_W'(i)) begin
        ent_nxt[i] = wr[0].data;
      end
      if (wr[1].en && wr[1].idx == SPEC_W'(i)) begin
        ent_nxt[i] = wr[1].data;
      end
    end
  end

  always_comb begin
    st_nxt.regs = ent_nxt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read ports
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < FP_RD_PORTS; p++) begin
      rd_data[p] = st_r.regs[rd_idx[p]];
    end
  end

endmodule

//--- hw/fdmu_move_unit.sv
// Purpose: decode and datapath for doubleword moves between integer and fp files
// Assumes: issue carries the integer register value already read by the pipeline
// Notes: one instruction per cycle, result one cycle after issue
module fdmu_move_unit
  import fdmu_pkg::*;
#(
  parameter int unsigned NUM_REGS = NUM_FP_REGS
) (
  input wire logic clk,
  input wire logic srst,
  input wire fdmu_issue_t issue,
  input wire fdmu_mode_t mode,
  input wire logic [SPEC_W-1:0] fp_obs_idx,
  output logic issue_ready,
  output fdmu_int_wr_t int_wr,
  output logic ri_exc,
  output logic to_done,
  output logic [XLEN-1:0] fp_obs_data
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_REGS != NUM_FP_REGS) begin : g_bad_regs
    $error("move unit serves only the full fp register set");
  end
  // the pair logic below is hard-wired to two write and three read ports
  if (XLEN != 2 * HALF_W) begin : g_bad_half
    $error("a doubleword must split into exactly two fp halves");
  end
  if (FP_WR_PORTS != 2) begin : g_bad_wr
    $error("pair writes need exactly two fp write ports");
  end
  if (FP_RD_PORTS != 3) begin : g_bad_rd
    $error("pair reads plus the observe port need three fp read ports");
  end
  if (FP_SPEC_HI - FP_SPEC_LO + 1 != SPEC_W) begin : g_bad_fp_spec
    $error("fp specifier field must match the fp register index width");
  end
  if (INT_SPEC_HI - INT_SPEC_LO + 1 != SPEC_W) begin : g_bad_int_spec
    $error("integer specifier field must match the register index width");
  end
  if (OPC_HI - OPC_LO + 1 != $bits(FP_COPROC_MAJOR_OPCODE)) begin : g_bad_major
    $error("major opcode field must match its encoding width");
  end
  if (SUB_HI - SUB_LO + 1 != $bits(TO_FP_SUBOP)) begin : g_bad_sub
    $error("sub-op field must match its encoding width");
  end
  if (PAD_HI + 1 != $bits(PAD_ZERO)) begin : g_bad_pad
    $error("pad field must match its encoding width");
  end
  if (RESULT_LATENCY != 1) begin : g_bad_latency
    $error("results are registered exactly once after issue");
  end

  fdmu_state_t st_r;
  fdmu_state_t st_nxt;

  logic [5:0] f_major;
  logic [4:0] f_sub;
  logic [SPEC_W-1:0] f_int_spec;
  logic [SPEC_W-1:0] f_fp_spec;
  logic [SPEC_W-1:0] f_fp_pair;
  logic [10:0] f_pad;
  logic is_fp_move;
  logic move_double_to_fp;
  logic move_double_from_fp;
  logic allowed;
  logic pair_ok;
  logic to_fire;
  logic from_fire;
  logic refuse;
  logic [XLEN-1:0] src_data;
  logic [XLEN-1:0] from_data;
  logic [HALF_W-1:0] even_lo;
  logic [HALF_W-1:0] odd_lo;
  fdmu_fp_wr_t [FP_WR_PORTS-1:0] fp_wr;
  logic [FP_RD_PORTS-1:0][SPEC_W-1:0] fp_rd_idx;
  logic [FP_RD_PORTS-1:0][XLEN-1:0] fp_rd_data;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    f_major = issue.instr[OPC_HI:OPC_LO];
    f_sub = issue.instr[SUB_HI:SUB_LO];
    f_int_spec = issue.instr[INT_SPEC_HI:INT_SPEC_LO];
    f_fp_spec = issue.instr[FP_SPEC_HI:FP_SPEC_LO];
    f_pad = issue.instr[PAD_HI:0];
    // other encodings belong to other fpu units, so they are simply ignored
    is_fp_move = issue.valid && f_major == FP_COPROC_MAJOR_OPCODE && f_pad == PAD_ZERO;
    move_double_to_fp = is_fp_move && f_sub == TO_FP_SUBOP;
    move_double_from_fp = is_fp_move && f_sub == FROM_FP_SUBOP;
  end

  // ----------------------------------------------------------------
  // mode checks
  // ----------------------------------------------------------------
  always_comb begin
    allowed = mode.dword_en && mode.level_ge3;
    // one width flag only: native 32-bit and emulation look alike here
    pair_ok = mode.fr64 || !f_fp_spec[0];
    f_fp_pair = f_fp_spec | 5'h01;
  end

  // ----------------------------------------------------------------
  // accepted and refused moves
  // ----------------------------------------------------------------
  always_comb begin
    to_fire = move_double_to_fp && allowed;
    from_fire = move_double_from_fp && allowed;
    // refused moves touch neither file, they only raise the exception
    refuse = (move_double_to_fp || move_double_from_fp) && !allowed;
  end

  // ----------------------------------------------------------------
  // fp register access
  // ----------------------------------------------------------------
  always_comb begin
    fp_rd_idx[0] = f_fp_spec;
    fp_rd_idx[1] = f_fp_pair;
    fp_rd_idx[2] = fp_obs_idx;
  end

  fdmu_fp_regfile #(
    .NUM_REGS(NUM_REGS)
  ) u_regfile (
    .clk(clk),
    .srst(srst),
    .wr(fp_wr),
    .rd_idx(fp_rd_idx),
    .rd_data(fp_rd_data)
  );

  // ----------------------------------------------------------------
  // move-to datapath
  // ----------------------------------------------------------------
  always_comb begin
    src_data = issue.int_rd_data;
    fp_wr[0].en = 1'b0;
    fp_wr[0].idx = f_fp_spec;
    fp_wr[0].data = {HALF_ZERO, src_data[HALF_W-1:0]};
    fp_wr[1].en = 1'b0;
    fp_wr[1].idx = f_fp_pair;
    fp_wr[1].data = {HALF_ZERO, src_data[XLEN-1:HALF_W]};
    // odd pair in 32-bit mode: write nothing, so no neighbour is disturbed
    if (to_fire && pair_ok) begin
      fp_wr[0].en = 1'b1;
      if (mode.fr64) begin
        fp_wr[0].data = src_data;
      end else begin
        fp_wr[1].en = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // move-from datapath
  // ----------------------------------------------------------------
  always_comb begin
    even_lo = fp_rd_data[0][HALF_W-1:0];
    odd_lo = fp_rd_data[1][HALF_W-1:0];
    if (mode.fr64) begin
      from_data = fp_rd_data[0];
    end else begin
      // upper halves are stored as zero, so only the low words count
      from_data = {odd_lo, even_lo};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // the fp write commits on the issue edge, so a read one cycle later
  // already sees it; no delay slot even where the older level allows one
  always_comb begin
    st_nxt = st_r;
    st_nxt.int_wr.valid = 1'b0;
    st_nxt.to_done = 1'b0;
    st_nxt.ri_exc = 1'b0;
    st_nxt.obs_data = fp_rd_data[2];
    // idx and data hold between move-froms, only valid pulses
    if (from_fire) begin
      st_nxt.int_wr.valid = 1'b1;
      st_nxt.int_wr.idx = f_int_spec;
      if (pair_ok) begin
        st_nxt.int_wr.data = from_data;
      end else begin
        // odd pair in 32-bit mode: deliver zero rather than half a pair
        st_nxt.int_wr.data = DATA_RST;
      end
    end
    if (to_fire) begin
      st_nxt.to_done = 1'b1;
    end
    if (refuse) begin
      st_nxt.ri_exc = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r.int_wr.valid <= 1'b0;
      st_r.int_wr.idx <= IDX_RST;
      st_r.int_wr.data <= DATA_RST;
      st_r.ri_exc <= 1'b0;
      st_r.to_done <= 1'b0;
      st_r.obs_data <= DATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // never stalls: every move finishes in one cycle
  assign issue_ready = 1'b1;
  // everything else comes straight from flip-flops
  assign int_wr = st_r.int_wr;
  assign ri_exc = st_r.ri_exc;
  assign to_done = st_r.to_done;
  assign fp_obs_data = st_r.obs_data;

endmodule

//--- tb/fdmu_move_unit_props.sv
// Purpose: port checks for the doubleword move unit
// Assumes: one clock, srst synchronous active high
// Notes: bound onto every fdmu_move_unit
module fdmu_move_unit_props
  import fdmu_pkg::*;
#(
  parameter int unsigned NUM_REGS = NUM_FP_REGS
) (
  input wire logic clk,
  input wire logic srst,
  input wire fdmu_issue_t issue,
  input wire fdmu_mode_t mode,
  input wire logic [SPEC_W-1:0] fp_obs_idx,
  input wire logic issue_ready,
  input wire fdmu_int_wr_t int_wr,
  input wire logic ri_exc,
  input wire logic to_done,
  input wire logic [XLEN-1:0] fp_obs_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cop, mv_to, mv_fr, en;
  logic [4:0] fp_spec;
  assign cop = issue.valid && issue.instr[31:26] == FP_COPROC_MAJOR_OPCODE;
  assign mv_to = cop && issue.instr[10:0] == PAD_ZERO && issue.instr[25:21] == TO_FP_SUBOP;
  assign mv_fr = cop && issue.instr[10:0] == PAD_ZERO && issue.instr[25:21] == FROM_FP_SUBOP;
  assign en = mode.dword_en && mode.level_ge3;
  assign fp_spec = issue.instr[15:11];
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_to;
    mv_to && en |=> to_done && !int_wr.valid && !ri_exc;
  endproperty
  a_to: assert property (p_to) else $error("move-to not committed");
  property p_from;
    mv_fr && en |=> int_wr.valid && int_wr.idx == $past(issue.instr[20:16]) && !to_done;
  endproperty
  a_from: assert property (p_from) else $error("move-from write missing");
  property p_ri;
    (mv_to || mv_fr) && !en |=> ri_exc && !to_done && !int_wr.valid;
  endproperty
  a_ri: assert property (p_ri) else $error("disabled move not refused");
  property p_pad;
    cop && issue.instr[10:0] != PAD_ZERO |=> !ri_exc && !to_done && !int_wr.valid;
  endproperty
  a_pad: assert property (p_pad) else $error("nonzero pad decoded");
  property p_fwd;
    mv_to && en && (mode.fr64 || !fp_spec[0]) ##1 mv_fr && en && fp_spec == $past(fp_spec)
      && $stable(mode.fr64) |=> int_wr.data == $past(issue.int_rd_data, 2);
  endproperty
  a_fwd: assert property (p_fwd) else $error("round trip mismatch");
  property p_odd;
    mv_fr && en && !mode.fr64 && fp_spec[0] |=> int_wr.valid && int_wr.data == DATA_RST;
  endproperty
  a_odd: assert property (p_odd) else $error("odd pair read not zero");
  property p_obs64;
    mv_to && en && mode.fr64 && fp_obs_idx == fp_spec ##1 $stable(fp_obs_idx)
      |=> fp_obs_data == $past(issue.int_rd_data, 2);
  endproperty
  a_obs64: assert property (p_obs64) else $error("wide register wrong");
  property p_obs32;
    mv_to && en && !mode.fr64 && !fp_spec[0] && fp_obs_idx == (fp_spec | 5'h01)
      ##1 $stable(fp_obs_idx)
      |=> fp_obs_data == {HALF_ZERO, $past(issue.int_rd_data[63:32], 2)};
  endproperty
  a_obs32: assert property (p_obs32) else $error("odd half wrong");
  c_to: cover property (mv_to && en);
  c_ri: cover property (ri_exc);
  c_odd: cover property (mv_fr && en && !mode.fr64 && fp_spec[0]);
endmodule

bind fdmu_move_unit fdmu_move_unit_props #(.NUM_REGS(NUM_REGS)) fdmu_move_unit_props_inst (
  .clk(clk), .srst(srst), .issue(issue), .mode(mode), .fp_obs_idx(fp_obs_idx),
  .issue_ready(issue_ready), .int_wr(int_wr), .ri_exc(ri_exc), .to_done(to_done),
  .fp_obs_data(fp_obs_data));

//--- tb/fdmu_int_pipe_model.sv
// Purpose: integer register file and read side of the pipeline
// Assumes: bench may preset entries between edges
// Notes: idle read bus shows the inverse of the last read
module fdmu_int_pipe_model
  import fdmu_pkg::*;
(
  input wire logic clk,
  input wire logic valid,
  input wire logic [SPEC_W-1:0] rd_idx,
  input wire fdmu_int_wr_t int_wr,
  output logic [XLEN-1:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [XLEN-1:0] int_regs [32];
  logic [XLEN-1:0] last;
  // reads come from the file only, never from a move-from still in flight
  assign rd_data = valid ? int_regs[rd_idx] : ~last;
  always @(posedge clk) begin
    if (valid)
      last <= int_regs[rd_idx];
    if (int_wr.valid)
      int_regs[int_wr.idx] <= int_wr.data;
  end
endmodule

//--- tb/fdmu_move_unit_test.sv
// Purpose: self-checking bench for the doubleword move unit
// Assumes: inputs change at the falling edge
// Notes: round trips from a table, refusals by hand
module fdmu_move_unit_test import fdmu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic fr64;
    logic [4:0] fp_spec;
    logic [63:0] data;
    logic [63:0] exp;
  } fdmu_row_t;
  localparam fdmu_row_t ROWS [5] = '{
    {1'b1, 5'h03, 64'h0123456789abcdef, 64'h0123456789abcdef},
    {1'b0, 5'h04, 64'hfedcba9876543210, 64'hfedcba9876543210},
    {1'b0, 5'h1f, 64'h5555aaaa5555aaaa, 64'h0},
    {1'b1, 5'h00, 64'hffffffffffffffff, 64'hffffffffffffffff},
    {1'b0, 5'h1e, 64'h8000000000000001, 64'h8000000000000001}};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic vld, ready, ri_exc, to_done;
  logic [31:0] instr;
  logic [4:0] obs_idx;
  logic [63:0] rd_data, obs_data;
  fdmu_mode_t mode;
  fdmu_issue_t issue;
  fdmu_int_wr_t int_wr;
  int n_fail = 0;
  int tests_run = 0;
  assign issue = {vld, instr, rd_data};
  always #2 clk = ~clk;
  fdmu_move_unit #(.NUM_REGS(32)) fdmu_move_unit_inst (.clk(clk), .srst(srst),
    .issue(issue), .mode(mode), .fp_obs_idx(obs_idx), .issue_ready(ready),
    .int_wr(int_wr), .ri_exc(ri_exc), .to_done(to_done), .fp_obs_data(obs_data));
  fdmu_int_pipe_model fdmu_int_pipe_model_inst (.clk(clk), .valid(vld),
    .rd_idx(instr[20:16]), .int_wr(int_wr), .rd_data(rd_data));
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    tests_run++;
    if (got !== want) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic op(input logic [4:0] sub, input logic [4:0] int_spec,
                    input logic [4:0] fp_spec, input logic [10:0] pad);
    @(negedge clk);
    vld = 1'b1;
    instr = {FP_COPROC_MAJOR_OPCODE, sub, int_spec, fp_spec, pad};
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    vld = 1'b0;
    instr = 32'h0;
    mode = 3'h7;
    obs_idx = 5'h00;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(64'({ready, to_done, ri_exc, int_wr.valid}), 64'h8);
    chk(obs_data, 64'h0);
    srst = 1'b0;
    // ----------------------------------------------------------------
    // round trips, move-from right behind move-to
    // ----------------------------------------------------------------
    foreach (ROWS[i]) begin
      mode.fr64 = ROWS[i].fr64;
      fdmu_int_pipe_model_inst.int_regs[1] = ROWS[i].data;
      obs_idx = ROWS[i].fp_spec | {4'h0, !ROWS[i].fr64};
      op(TO_FP_SUBOP, 5'h01, ROWS[i].fp_spec, PAD_ZERO);
      op(FROM_FP_SUBOP, 5'h02, ROWS[i].fp_spec, PAD_ZERO);
      chk(64'(to_done), 64'h1);
      @(negedge clk);
      chk(64'({int_wr.valid, int_wr.idx}), 64'h22);
      chk(int_wr.data, ROWS[i].exp);
      if (ROWS[i].fr64 || !ROWS[i].fp_spec[0])
        chk(obs_data, ROWS[i].fr64 ? ROWS[i].data : {HALF_ZERO, ROWS[i].data[63:32]});
      vld = 1'b0;
    end
    // ----------------------------------------------------------------
    // refusals and words that must be ignored
    // ----------------------------------------------------------------
    mode = 3'h7;
    obs_idx = 5'h06;
    for (int k = 0; k < 2; k++) begin
      mode = k ? 3'h5 : 3'h6;
      op(k ? TO_FP_SUBOP : FROM_FP_SUBOP, 5'h01, 5'h06, PAD_ZERO);
      @(negedge clk);
      chk(64'({ri_exc, to_done, int_wr.valid}), 64'h4);
      vld = 1'b0;
    end
    mode = 3'h7;
    for (int k = 0; k < 2; k++) begin
      op(k ? 5'h06 : TO_FP_SUBOP, 5'h01, 5'h06, k ? PAD_ZERO : 11'h001);
      @(negedge clk);
      chk(64'({ri_exc, to_done, int_wr.valid}), 64'h0);
      vld = 1'b0;
    end
    @(negedge clk);
    chk(obs_data, 64'h0);
    end_of_test();
  end
endmodule
